// file: core/sar_adc_control.sv
// Successive-approximation converter control, registers and sequencing
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module sar_adc_control #(
   parameter int ADDR_W = 16  // Register address width
) (
   input wire logic REF_CLK_I,             // 125 MHz system clock
   input wire logic SRST_I,                // Synchronous reset
   input wire logic [ADDR_W-1:0] ADDR_I,   // Register address
   input wire logic [7:0] WDATA_I,         // Write data
   input wire logic WR_I,                  // Write strobe
   input wire logic RD_I,                  // Read strobe
   output logic [7:0] RDATA_O,             // Read data, one cycle later
   input wire logic OSC_CLK_EN_I,          // oscillator_out_clock enable
   input wire logic BUS_CLK_EN_I,          // Bus clock enable
   input wire logic STOP_I,                // Processor in stop mode
   input wire logic WAIT_I,                // Processor in wait mode
   input wire logic COMP_I,                // Comparator, input >= trial
   output logic [7:0] TRIAL_O,             // Trial code to the DAC
   output logic [4:0] MUX_SEL_O,           // selected_analog_input code
   output logic SAMPLE_O,                  // Sample switch closed
   output logic POWER_DOWN_O,              // Analog section off
   input wire logic [3:0] PORT_PIN_I,      // port_b_analog_pins levels
   input wire logic [3:0] PORT_LATCH_I,    // Port output latch
   input wire logic [3:0] PORT_DIR_I,      // Port direction bits
   output logic [3:0] PORT_OVERRIDE_O,     // Pin taken, block port writes
   output logic [3:0] PORT_READ_O,         // Value a port read returns
   output logic IRQ_O,                     // Processor interrupt request
   output logic DMA_REQ_O,                 // Direct memory access request
   output logic WAKE_O                     // Wake from wait
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W < 16) begin : g_bad_addr
      $error("sar_adc_control: ADDR_W must reach the register offsets");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   sar_adc_pkg::status_ctrl_s scr_r;     // Status and control
   sar_adc_pkg::status_ctrl_s scr_nxt;
   sar_adc_pkg::status_ctrl_s wr_val;    // Written status value
   sar_adc_pkg::clock_cfg_s clk_cfg_r;   // Clock configuration
   sar_adc_pkg::conv_state_e state_r;    // Sequencer state
   sar_adc_pkg::conv_state_e state_nxt;
   logic [3:0] step_r;                   // Tick index in a conversion
   logic [3:0] step_nxt;
   logic [7:0] trial_r;                  // Trial code
   logic [7:0] trial_nxt;
   logic [7:0] mask_r;                   // Bit under trial
   logic [7:0] mask_nxt;
   logic [7:0] result_r;                 // Conversion result
   logic [7:0] rdata_r;                  // Read data holding
   logic [7:0] rdata_nxt;
   logic irq_pend_r;                     // Conversion request pending
   logic irq_pend_nxt;
   logic stop_q_r;                       // Stop level one cycle ago
   logic [4:0] sync1_r;                  // First sync stage
   logic [4:0] sync2_r;                  // Second sync stage
   logic [4:0] sync3_r;                  // Third sync stage
   logic [4:0] level_r;                  // Filtered async levels
   logic [3:0] port_read_r;              // Registered port read value
   logic [4:0] async_in;                 // Pins and comparator
   logic tick;                           // Converter clock tick
   logic div_clear;                      // Restart the tick phase
   logic wr_scr;                         // Status-control write
   logic wr_clk;                         // Clock config write
   logic rd_res;                         // Result read
   logic chan_off;                       // Channel is power-off code
   logic start;                          // Write launches a conversion
   logic resume;                         // Stop exit relaunch
   logic done;                           // Conversion completes now
   logic converting;                     // Sequencer busy
   logic comp_ok;                        // Stable comparator level
   logic [7:0] kept;                     // Trial after decision

   // ----------------------------------------------------------------
   // Input synchronisers: pins and comparator, three flops each
   // ----------------------------------------------------------------
   assign async_in = {COMP_I, PORT_PIN_I};

   for (genvar i = 0; i < 5; i++) begin : g_sync
      // A change counts once stages two and three agree
      always_ff @(posedge REF_CLK_I) begin
         if (SRST_I) begin
            sync1_r[i] <= 1'b0;
            sync2_r[i] <= 1'b0;
            sync3_r[i] <= 1'b0;
            level_r[i] <= 1'b0;
         end else begin
            sync1_r[i] <= async_in[i];
            sync2_r[i] <= sync1_r[i];
            sync3_r[i] <= sync2_r[i];
            if (sync2_r[i] == sync3_r[i]) begin
               level_r[i] <= sync3_r[i];
            end
         end
      end
   end

   assign comp_ok = level_r[4];

   // ----------------------------------------------------------------
   // Port sharing
   // ----------------------------------------------------------------
   for (genvar p = 0; p < 4; p++) begin : g_port
      // Selected pin is analog; port and direction writes blocked
      assign PORT_OVERRIDE_O[p] = (scr_r.channel_select_field == 5'(p));

      // Read: latch when output, else zero if taken, else pin
      always_ff @(posedge REF_CLK_I) begin
         if (SRST_I) begin
            port_read_r[p] <= 1'b0;
         end else if (PORT_DIR_I[p]) begin
            port_read_r[p] <= PORT_LATCH_I[p];
         end else begin
            port_read_r[p] <= !PORT_OVERRIDE_O[p] && level_r[p];
         end
      end
   end

   assign PORT_READ_O = port_read_r;

   // ----------------------------------------------------------------
   // Converter clock
   // ----------------------------------------------------------------
   // Each start restarts the tick phase, so a run spans 16 full ticks
   assign div_clear = SRST_I || wr_scr || resume;

   sar_clock_divider #(
      .DIV_W(4)
   ) u_divider (
      .clk_i(REF_CLK_I),
      .srst_i(div_clear),
      .src_bus_i(clk_cfg_r.conv_clock_source_select),
      .prescale_i(clk_cfg_r.conv_clock_prescale),
      .osc_en_i(OSC_CLK_EN_I),
      .bus_en_i(BUS_CLK_EN_I),
      .tick_o(tick)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign wr_scr = WR_I && (ADDR_I == sar_adc_pkg::STATUS_CTRL_ADDR);
   assign wr_clk = WR_I && (ADDR_I == sar_adc_pkg::CLOCK_CFG_ADDR);
   assign rd_res = RD_I && (ADDR_I == sar_adc_pkg::RESULT_ADDR);
   assign wr_val = sar_adc_pkg::status_ctrl_s'(WDATA_I);

   // ----------------------------------------------------------------
   // Sequencing decode
   // ----------------------------------------------------------------
   // All-ones channel keeps the converter powered down
   assign chan_off =
      (scr_r.channel_select_field == sar_adc_pkg::CHAN_POWER_OFF);
   assign converting = (state_r == sar_adc_pkg::ST_CONVERT);
   // A control write outside stop starts, unless it selects power-off
   assign start = wr_scr && !STOP_I &&
      (wr_val.channel_select_field != sar_adc_pkg::CHAN_POWER_OFF);
   // Continuous mode picks up again when stop is left
   assign resume = stop_q_r && !STOP_I && !wr_scr && !converting &&
                   scr_r.continuous_conv_bit && !chan_off;
   // Sixteenth tick ends it; a write in that cycle restarts
   assign done = converting && tick && !STOP_I && !wr_scr &&
                 (step_r == sar_adc_pkg::STEP_LAST);
   // Keep the bit under trial only if the input reached the code
   assign kept = comp_ok ? trial_r : (trial_r & ~mask_r);

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      step_nxt = step_r;
      trial_nxt = trial_r;
      mask_nxt = mask_r;
      if (STOP_I) begin
         // Stop aborts whatever is running
         state_nxt = sar_adc_pkg::ST_IDLE;
         step_nxt = '0;
         trial_nxt = '0;
         mask_nxt = '0;
      end else if (wr_scr || resume) begin
         // Abandon and restart from the first step, or go idle if power-off is written
         state_nxt = (start || resume) ? sar_adc_pkg::ST_CONVERT :
                     sar_adc_pkg::ST_IDLE;
         step_nxt = '0;
         trial_nxt = '0;
         mask_nxt = '0;
      end else if (converting && tick) begin
         case (step_r)
            sar_adc_pkg::STEP_LAST: begin
               // Repeat while continuous, else one and stop
               state_nxt = (scr_r.continuous_conv_bit && !chan_off) ?
                           sar_adc_pkg::ST_CONVERT : sar_adc_pkg::ST_IDLE;
               step_nxt = '0;
               trial_nxt = '0;
               mask_nxt = '0;
            end
            default: begin
               step_nxt = step_r + 4'h1;
               if (step_r == sar_adc_pkg::STEP_FIRST_TRIAL - 4'h1) begin
                  // Sampling over, first trial is the top bit
                  trial_nxt = sar_adc_pkg::TRIAL_MSB;
                  mask_nxt = sar_adc_pkg::TRIAL_MSB;
               end else if (step_r >= sar_adc_pkg::STEP_FIRST_TRIAL) begin
                  trial_nxt = kept | (mask_r >> 1);
                  mask_nxt = mask_r >> 1;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status-control next value
   // ----------------------------------------------------------------
   always_comb begin
      scr_nxt = scr_r;
      if (wr_scr) begin
         scr_nxt = wr_val;
         // Done flag only writable with interrupts enabled
         scr_nxt.conv_done_flag = wr_val.conv_irq_enable &&
                                  wr_val.conv_done_flag;
      end else if (rd_res && !scr_r.conv_irq_enable) begin
         // Result read clears the flag
         scr_nxt.conv_done_flag = 1'b0;
      end
      if (done && !scr_r.conv_irq_enable) begin
         // Completion sets the flag, winning over a clear
         scr_nxt.conv_done_flag = 1'b1;
      end
   end

   // Request set at completion, dropped by read or write
   assign irq_pend_nxt = (done && scr_r.conv_irq_enable) ||
                         (irq_pend_r && !wr_scr && !rd_res);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (RD_I) begin
         case (ADDR_I)
            sar_adc_pkg::STATUS_CTRL_ADDR: rdata_nxt = scr_r;
            sar_adc_pkg::RESULT_ADDR: rdata_nxt = result_r;
            sar_adc_pkg::CLOCK_CFG_ADDR: rdata_nxt = clk_cfg_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Control registers; reset loads power-off and clears bits
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         scr_r <= sar_adc_pkg::STATUS_CTRL_RESET;
         clk_cfg_r <= sar_adc_pkg::CLOCK_CFG_RESET;
         irq_pend_r <= 1'b0;
         rdata_r <= 8'h00;
         stop_q_r <= 1'b0;
      end else begin
         scr_r <= scr_nxt;
         if (wr_clk) begin
            // Oscillator is the reset source
            clk_cfg_r <= {WDATA_I[7:4], 4'h0};
         end
         irq_pend_r <= irq_pend_nxt;
         rdata_r <= rdata_nxt;
         stop_q_r <= STOP_I;
      end
   end

   // Sequencer and result registers
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         state_r <= sar_adc_pkg::ST_IDLE;
         step_r <= '0;
         trial_r <= '0;
         mask_r <= '0;
         result_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         step_r <= step_nxt;
         trial_r <= trial_nxt;
         mask_r <= mask_nxt;
         if (done) begin
            // Every completion overwrites the result
            result_r <= kept;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign RDATA_O = rdata_r;
   assign TRIAL_O = trial_r;
   // Any five-bit code goes to the mux; unused ones are undefined
   assign MUX_SEL_O = scr_r.channel_select_field;
   assign SAMPLE_O = converting &&
                     (step_r < sar_adc_pkg::STEP_FIRST_TRIAL);
   assign POWER_DOWN_O = chan_off || STOP_I;
   // Flag clear gives CPU request, flag set gives DMA request
   assign IRQ_O = irq_pend_r && !scr_r.conv_done_flag;
   assign DMA_REQ_O = irq_pend_r && scr_r.conv_done_flag;
   // Running in wait, the CPU request wakes the processor
   assign WAKE_O = IRQ_O && WAIT_I;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   localparam logic [4:0] TICKS_AT_DONE = 5'h0F;
   logic [4:0] ticks_seen_r;   // Ticks since conversion began
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I || !converting || step_nxt == '0 && !tick) begin
         ticks_seen_r <= (converting && tick) ? 5'h01 : 5'h00;
      end else if (tick) begin
         ticks_seen_r <= ticks_seen_r + 5'h01;
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);

   conv_length_a: assert property (
      done |-> step_r == 4'hF && ticks_seen_r >= TICKS_AT_DONE)
      else $error("conversion did not last sixteen ticks");
   write_starts_a: assert property (
      start |=> converting && step_r == 4'h0)
      else $error("control write did not restart conversion");
   pin_taken_a: assert property (
      (MUX_SEL_O <= 5'h03) |-> PORT_OVERRIDE_O[MUX_SEL_O[1:0]])
      else $error("selected pin not taken over");
   result_load_a: assert property (
      done |=> result_r == $past(kept))
      else $error("result not loaded at completion");
   cont_repeat_a: assert property (
      done && scr_r.continuous_conv_bit && !chan_off
      |=> converting && step_r == 4'h0)
      else $error("continuous mode did not repeat");
   single_stop_a: assert property (
      done && !scr_r.continuous_conv_bit
      |=> !converting ##1 (!converting || $past(start)))
      else $error("single mode converted again");
   flag_set_a: assert property (
      done && !scr_r.conv_irq_enable |=> scr_r.conv_done_flag)
      else $error("done flag not set");
   flag_clear_a: assert property (
      rd_res && !done && !wr_scr && !scr_r.conv_irq_enable
      |=> !scr_r.conv_done_flag)
      else $error("result read left done flag set");
   irq_raise_a: assert property (
      done && scr_r.conv_irq_enable |=> irq_pend_r && (IRQ_O || DMA_REQ_O))
      else $error("no request after enabled completion");
   irq_drop_a: assert property (
      (rd_res || wr_scr) && !done |=> !IRQ_O && !DMA_REQ_O)
      else $error("request not withdrawn");
   stop_abort_a: assert property (
      STOP_I |-> POWER_DOWN_O ##1 !converting)
      else $error("stop did not abort conversion");
   power_off_a: assert property (
      chan_off && !$past(wr_scr) |-> !converting)
      else $error("converter ran while powered down");
   reset_state_a: assert property (@(posedge REF_CLK_I)
      disable iff (1'b0)
      SRST_I |=> scr_r == sar_adc_pkg::STATUS_CTRL_RESET)
      else $error("reset values wrong");

   single_cov_c: cover property (done && !scr_r.continuous_conv_bit);
   cont_cov_c: cover property (done ##[1:300] done);
   stop_cov_c: cover property (converting && STOP_I);
   irq_cov_c: cover property (IRQ_O && WAIT_I);

endmodule // sar_adc_control

// file: core/sar_clock_divider.sv
// Converter clock enable: source select and power-of-two prescaler
`timescale 1ns/100ps
module sar_clock_divider #(
   parameter int DIV_W = 4  // Counter width, must cover divide by 16
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic src_bus_i,        // 1 = bus enable, 0 = oscillator
   input wire logic [2:0] prescale_i,  // Divide ratio code
   input wire logic osc_en_i,         // Oscillator clock enable pulse
   input wire logic bus_en_i,         // Bus clock enable pulse
   output logic tick_o                // One-cycle converter tick
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   if (DIV_W < 4) begin : g_bad_width
      $error("sar_clock_divider: DIV_W below 4 cannot divide by 16");
   end

   logic [DIV_W-1:0] count_r;   // Source pulses seen in this period
   logic [DIV_W-1:0] count_nxt; // Next count
   logic [DIV_W-1:0] last;      // Terminal count, ratio minus one
   logic src_en;                // Selected source pulse

   // Source select, bus when set
   assign src_en = src_bus_i ? bus_en_i : osc_en_i;

   // Ratio 1,2,4,8 from low codes, 16 for any top-bit code
   assign last = (prescale_i >= sar_adc_pkg::PRESCALE_MAX) ?
                 DIV_W'(4'hF) :
                 DIV_W'((4'h1 << prescale_i[1:0]) - 4'h1);

   assign tick_o = src_en && (count_r >= last);
   assign count_nxt = tick_o ? '0 : count_r + DIV_W'(src_en);

   // Prescaler counter
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         count_r <= '0;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule // sar_clock_divider

// file: include/sar_adc_pkg.sv
// Constants, field layouts and types shared by the converter control block
// How it works
// - Status-control write starts conversion, 16-17 ticks
// - Selected port pin forced analog, reads masked
// - Continuous results overwrite the result register
// - Continuous mode repeats until its bit clears
// - Done flag set after first continuous conversion
// - Done flag read-only when interrupts are off
// - Enabled end of conversion raises CPU/DMA request
// - Result read or control write drops request
// - Single mode performs exactly one conversion
// - Reset clears enable, continuous bit, done flag
// - Five-bit channel code selects port or reference
// - Unused channel codes give undefined results
// - Channel all ones powers down, reset value
// - Converter keeps running in wait, wakes CPU
// - Stop aborts conversion, resumes after stop; here only continuous mode resumes
// - Eight-bit result updated at every completion
// - Prescaler divides by 1, 2, 4, 8, 16
// - Source bit: 1 bus clock, 0 oscillator
package sar_adc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] STATUS_CTRL_ADDR = 16'h003C; // Control/status
   localparam logic [15:0] RESULT_ADDR = 16'h003D;      // Result, read only
   localparam logic [15:0] CLOCK_CFG_ADDR = 16'h003E;   // Clock setup

   // ----------------------------------------------------------------
   // Field layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic conv_done_flag;          // Bit 7
      logic conv_irq_enable;         // Bit 6
      logic continuous_conv_bit;     // Bit 5
      logic [4:0] channel_select_field; // Bits 4..0
   } status_ctrl_s;

   typedef struct packed {
      logic [2:0] conv_clock_prescale;    // Bits 7..5
      logic conv_clock_source_select;     // Bit 4, 1 = bus clock
      logic [3:0] unused;                 // Bits 3..0 read zero
   } clock_cfg_s;

   localparam status_ctrl_s STATUS_CTRL_RESET = 8'h1F;
   localparam clock_cfg_s CLOCK_CFG_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Channel codes
   // ----------------------------------------------------------------
   localparam logic [4:0] CHAN_PORT_LAST = 5'h03;  // Codes 0..3 are pins
   localparam logic [4:0] CHAN_HIGH_REF = 5'h1D;   // high_reference_node
   localparam logic [4:0] CHAN_GROUND = 5'h1E;     // analog_ground_node
   localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;  // Converter off

   // ----------------------------------------------------------------
   // Conversion sequencing, in converter clock ticks
   // ----------------------------------------------------------------
   localparam logic [3:0] STEP_FIRST_TRIAL = 4'h8; // Ticks 0..7 sample
   localparam logic [3:0] STEP_LAST = 4'hF;        // Sixteenth tick ends
   localparam logic [7:0] TRIAL_MSB = 8'h80;       // First trial bit

   // Prescale field with the top bit set always means divide by 16
   localparam logic [2:0] PRESCALE_MAX = 3'h4;

   typedef enum logic {ST_IDLE, ST_CONVERT} conv_state_e;

endpackage

// file: verif/sar_adc_control_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module sar_adc_control_tb_top;
   localparam int MAX_CYC = 20000; // Whole run fits well inside this
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, wt = 1'b0;
   logic stp = 1'b0, bus_en = 1'b0, smp, pwd, irq, dma, wake;
   logic [15:0] adr = 16'h0000; // Register address
   logic [7:0] wd = 8'h00, rdat, vin = 8'h00, trial, got;
   logic [4:0] msel;
   logic [3:0] ovr, prd, pl = 4'h0, pd = 4'h0;
   int error_cnt = 0, n_tests = 0, cyc = 0, seed = 88947, n;
   always #4 clk = ~clk;
   // Bus clock enable runs at half rate to tell the sources apart
   always @(posedge clk) bus_en <= ~bus_en;
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == MAX_CYC) begin
         error_cnt++;
         finish_test();
      end
   end
   // Comparator follows the analog input against the trial code
   sar_adc_control i_dut (.REF_CLK_I(clk), .SRST_I(rst), .ADDR_I(adr),
      .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
      .OSC_CLK_EN_I(1'b1), .BUS_CLK_EN_I(bus_en), .STOP_I(stp),
      .WAIT_I(wt), .COMP_I(vin >= trial), .TRIAL_O(trial),
      .MUX_SEL_O(msel), .SAMPLE_O(smp), .POWER_DOWN_O(pwd),
      .PORT_PIN_I(vin[3:0]), .PORT_LATCH_I(pl), .PORT_DIR_I(pd),
      .PORT_OVERRIDE_O(ovr), .PORT_READ_O(prd), .IRQ_O(irq),
      .DMA_REQ_O(dma), .WAKE_O(wake));
   // ----------------------------------------------------------
   // Bus cycles and comparisons
   // ----------------------------------------------------------
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [15:0] a);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(posedge clk) got = rdat;
   endtask
   // Poll the done flag, n counts cycles since the start write
   task automatic wait_done();
      n = 0;
      do begin
         rreg(16'h003C);
         n += 2;
      end while (got[7] !== 1'b1 && n < 800);
   endtask
   // Wait for a processor (0) or memory-access (1) request
   task automatic wait_req(input bit d);
      n = 0;
      while ((d ? dma : irq) !== 1'b1 && n < 800) begin
         @(posedge clk);
         n++;
      end
   endtask
   // One single conversion on a fresh random input, p = tick period
   task automatic conv(input logic [7:0] ctl, input int p);
      vin <= $random(seed);
      wreg(16'h003C, ctl);
      chk({3'h0, msel}, {3'h0, ctl[4:0]});
      chk({7'h0, smp}, 8'h01);
      chk({4'h0, ovr}, ctl[4:2] == 3'h0 ? 8'h01 << ctl[1:0] : 8'h00);
      wait_done();
      chk({7'h0, n >= 16 * p - 2 && n <= 17 * p + 4}, 8'h01);
      rreg(16'h003D);
      chk(got, vin);
      rreg(16'h003C);
      chk(got, {3'h0, ctl[4:0]});
   endtask
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      logic [2:0] pr;
      int per; // Cycles per converter tick
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rreg(16'h003C);
      chk(got, 8'h1F);
      chk({7'h0, pwd}, 8'h01);
      rreg(16'h003E);
      chk(got, 8'h00);
      rreg(16'h0050);
      chk(got, 8'h00);
      // Leaving power-off: one throwaway conversion to settle
      wreg(16'h003C, 8'h00);
      wait_done();
      // Sources, prescales and every pin and reference channel code
      for (int i = 0; i < 6; i++) begin
         pr = i < 2 ? 3'h3 : (i < 4 ? 3'h4 : 3'h7);
         wreg(16'h003E, {pr, i[0], 4'h0});
         rreg(16'h003E);
         chk(got, {pr, i[0], 4'h0});
         per = (pr == 3'h3 ? 8 : 16) * (i[0] ? 2 : 1);
         conv({3'h0, i < 4 ? 5'(i) : 5'(25 + i)}, per);
      end
      // Selected pin reads 0 with direction 0, else the latch
      wreg(16'h003E, 8'h60);
      conv(8'h02, 8);
      pl <= 4'hF;
      repeat (3) @(posedge clk);
      chk({7'h0, prd[2]}, 8'h00);
      pd <= 4'hF;
      repeat (3) @(posedge clk);
      chk({4'h0, prd}, 8'h0F);
      // Continuous mode overwrites unread results, flag stays set
      wreg(16'h003C, 8'h21);
      wait_done();
      vin <= vin ^ 8'hA5;
      repeat (300) @(posedge clk);
      rreg(16'h003C);
      chk(got, 8'hA1);
      rreg(16'h003D);
      chk(got, vin);
      conv(8'h01, 8);
      repeat (300) @(posedge clk);
      rreg(16'h003C);
      chk(got, 8'h01);
      // Processor request, wake from wait, then memory-access request
      wt <= 1'b1;
      wreg(16'h003C, 8'h42);
      wait_req(1'b0);
      chk({6'h0, irq, wake}, 8'h03);
      rreg(16'h003D);
      chk({7'h0, irq}, 8'h00);
      wreg(16'h003C, 8'hC2);
      wait_req(1'b1);
      chk({6'h0, dma, irq}, 8'h02);
      wreg(16'h003C, 8'h02);
      chk({7'h0, dma}, 8'h00);
      // Stop aborts a single conversion, a new write converts after
      wt <= 1'b0;
      repeat (40) @(posedge clk);
      stp <= 1'b1;
      repeat (2) @(posedge clk);
      chk({7'h0, pwd}, 8'h01);
      repeat (300) @(posedge clk);
      stp <= 1'b0;
      rreg(16'h003C);
      chk(got, 8'h02);
      repeat (130) @(posedge clk);
      conv(8'h03, 8);
      finish_test();
   end
endmodule // sar_adc_control_tb_top
